// [include/crrs_params.svh]
// Constants for the return, rotate, sleep and subtract executor.
// Assumes an 8-bit data path and a 15-bit instruction pointer.
`ifndef CRRS_PARAMS_SVH
`define CRRS_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define CRRS_DATA_W      8
`define CRRS_FADDR_W     7
`define CRRS_PTR_W       15
`define CRRS_WDT_W       8
`define CRRS_PRE_W       8

// ----------------------------------------------------------------
// Reset and clear values, destination select codes
// ----------------------------------------------------------------
`define CRRS_W_RST       8'h00
`define CRRS_PTR_RST     15'h0000
`define CRRS_WDT_CLR     8'h00
`define CRRS_PRE_CLR     8'h00
`define CRRS_DEST_W      1'b0
`define CRRS_DEST_F      1'b1

`endif

// [include/crrs_pkg.sv]
// Types for the return, rotate, sleep and subtract executor.
// Assumes the decoder upstream maps opcodes onto crrs_op_t.
package crrs_pkg;

	// ------------------------------------------------------------
	// Instruction selector
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CRRS_OP_NONE,
		CRRS_OP_LITERAL_RETURN,
		CRRS_OP_RETURN,
		CRRS_OP_ROTATE_RIGHT_CARRY,
		CRRS_OP_SLEEP,
		CRRS_OP_FILE_MINUS_ACCUMULATOR
	} crrs_op_t;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CRRS_ST_IDLE,
		CRRS_ST_SECOND,
		CRRS_ST_SLEEP
	} crrs_state_t;

endpackage

// [verilog/crrs_core.sv]
// Executor for literal return, subroutine return, rotate, sleep and subtract.
// Assumes the file register data and stack head come from logic on i_clk.
//
// What this block does
// RULE1: literal_return loads the working register with the 8-bit literal.
// RULE2: literal_return pops stack into instruction_pointer; two cycles, one word.
// RULE3: return pops stack into instruction_pointer, two cycles, flags untouched.
// RULE4: Rotate right through carry; old carry to bit 7, bit 0 to carry.
// RULE5: Rotate destination bit 0 writes working register, 1 writes file register.
// RULE6: Sleep clears watchdog_counter and its prescaler to zero.
// RULE7: Sleep clears power_down_flag, sets timeout_flag, then enters sleep state.
// RULE8: Subtract computes file value minus working register, two's complement.
// RULE9: Subtract destination bit 0 writes working register, 1 writes file register.
// RULE10: Carry and half_carry mean no borrow; zero flags a zero result.
`timescale 1ns/1ps
`include "crrs_params.svh"

module crrs_core
	import crrs_pkg::*;
(
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rstn,
	// Instruction request
	input  wire logic                      i_valid,
	input  crrs_op_t                       i_op,
	input  wire logic [`CRRS_DATA_W-1:0]   i_lit,
	input  wire logic [`CRRS_FADDR_W-1:0]  i_faddr,
	input  wire logic                      i_dest,
	output logic                           o_ready,
	// Operands from file and stack
	input  wire logic [`CRRS_DATA_W-1:0]   i_fdata,
	input  wire logic [`CRRS_PTR_W-1:0]    i_stack_head_value,
	// Wake from sleep
	input  wire logic                      i_wake,
	// File register write
	output logic                           o_fwrite,
	output logic [`CRRS_FADDR_W-1:0]       o_faddr,
	output logic [`CRRS_DATA_W-1:0]        o_fwdata,
	// Stack and instruction pointer
	output logic                           o_pop,
	output logic [`CRRS_PTR_W-1:0]         o_instruction_pointer,
	// Core state
	output logic [`CRRS_DATA_W-1:0]        o_w,
	output logic                           o_carry,
	output logic                           o_half_carry,
	output logic                           o_zero,
	output logic                           o_power_down_flag_n,
	output logic                           o_timeout_flag_n,
	output logic                           o_sleep,
	output logic [`CRRS_WDT_W-1:0]         o_watchdog_counter
);

	// ------------------------------------------------------------
	// Request decode and datapath
	// ------------------------------------------------------------
	crrs_state_t                 state_q;
	logic [`CRRS_PRE_W-1:0]      pre_q;
	logic                        acc;
	logic [`CRRS_DATA_W:0]       diff;
	logic [4:0]                  ndiff;
	logic [`CRRS_DATA_W-1:0]     rot;
	logic [`CRRS_DATA_W-1:0]     res;

	assign o_ready = (state_q == CRRS_ST_IDLE);
	assign o_sleep = (state_q == CRRS_ST_SLEEP);
	assign acc     = i_valid && o_ready;
	assign rot     = {o_carry, i_fdata[`CRRS_DATA_W-1:1]};                  // RULE4
	assign diff    = {1'b0, i_fdata} - {1'b0, o_w};                         // RULE8
	assign ndiff   = {1'b0, i_fdata[3:0]} - {1'b0, o_w[3:0]};
	assign res     = (i_op == CRRS_OP_ROTATE_RIGHT_CARRY) ? rot
	                                                     : diff[`CRRS_DATA_W-1:0];

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= CRRS_ST_IDLE;
		end else begin
			unique case (state_q)
				CRRS_ST_IDLE: begin
					if (acc && (i_op == CRRS_OP_LITERAL_RETURN ||
					            i_op == CRRS_OP_RETURN)) begin
						state_q <= CRRS_ST_SECOND;                              // RULE2 RULE3
					end else if (acc && i_op == CRRS_OP_SLEEP) begin
						state_q <= CRRS_ST_SLEEP;                               // RULE7
					end
				end
				CRRS_ST_SECOND: begin
					state_q <= CRRS_ST_IDLE;
				end
				CRRS_ST_SLEEP: begin
					if (i_wake) begin
						state_q <= CRRS_ST_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Working register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_w <= `CRRS_W_RST;
		end else if (acc && i_op == CRRS_OP_LITERAL_RETURN) begin
			o_w <= i_lit;                                                       // RULE1
		end else if (acc && i_dest == `CRRS_DEST_W &&
		             (i_op == CRRS_OP_ROTATE_RIGHT_CARRY ||
		              i_op == CRRS_OP_FILE_MINUS_ACCUMULATOR)) begin
			o_w <= res;                                                         // RULE5 RULE9
		end
	end

	// ------------------------------------------------------------
	// File register write-back
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_fwrite <= 1'b0;
			o_faddr  <= '0;
			o_fwdata <= '0;
		end else begin
			o_fwrite <= acc && i_dest == `CRRS_DEST_F &&
			            (i_op == CRRS_OP_ROTATE_RIGHT_CARRY ||
			             i_op == CRRS_OP_FILE_MINUS_ACCUMULATOR);                // RULE5 RULE9
			if (acc) begin
				o_faddr  <= i_faddr;
				o_fwdata <= res;
			end
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_carry      <= 1'b0;
			o_half_carry <= 1'b0;
			o_zero       <= 1'b0;
		end else if (acc && i_op == CRRS_OP_ROTATE_RIGHT_CARRY) begin
			o_carry <= i_fdata[0];                                              // RULE4
		end else if (acc && i_op == CRRS_OP_FILE_MINUS_ACCUMULATOR) begin
			o_carry      <= ~diff[`CRRS_DATA_W];                                // RULE10
			o_half_carry <= ~ndiff[4];                                          // RULE10
			o_zero       <= (diff[`CRRS_DATA_W-1:0] == '0);                     // RULE10
		end
	end

	// ------------------------------------------------------------
	// Return stack pop and instruction pointer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pop                 <= 1'b0;
			o_instruction_pointer <= `CRRS_PTR_RST;
		end else begin
			o_pop <= acc && (i_op == CRRS_OP_LITERAL_RETURN ||
			                 i_op == CRRS_OP_RETURN);                           // RULE2 RULE3
			if (acc && (i_op == CRRS_OP_LITERAL_RETURN || i_op == CRRS_OP_RETURN)) begin
				o_instruction_pointer <= i_stack_head_value;                    // RULE2 RULE3
			end
		end
	end

	// ------------------------------------------------------------
	// Power flags
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_power_down_flag_n <= 1'b1;
			o_timeout_flag_n    <= 1'b1;
		end else if (acc && i_op == CRRS_OP_SLEEP) begin
			o_power_down_flag_n <= 1'b0;                                        // RULE7
			o_timeout_flag_n    <= 1'b1;                                        // RULE7
		end
	end

	// ------------------------------------------------------------
	// Watchdog counter and prescaler
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pre_q              <= `CRRS_PRE_CLR;
			o_watchdog_counter <= `CRRS_WDT_CLR;
		end else if (acc && i_op == CRRS_OP_SLEEP) begin
			pre_q              <= `CRRS_PRE_CLR;                                // RULE6
			o_watchdog_counter <= `CRRS_WDT_CLR;                                // RULE6
		end else begin
			pre_q <= pre_q + 1'b1;
			if (pre_q == '1) begin
				o_watchdog_counter <= o_watchdog_counter + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	litret_w_a: assert property (acc && i_op == CRRS_OP_LITERAL_RETURN // RULE1
		|=> o_w == $past(i_lit))
		else $error("literal return did not load W");
	litret_pop_a: assert property (acc && i_op == CRRS_OP_LITERAL_RETURN // RULE2
		|=> o_pop && !o_ready
		&& o_instruction_pointer == $past(i_stack_head_value) ##1 !o_pop && o_ready)
		else $error("literal return pop or timing wrong");
	return_flags_a: assert property (acc && i_op == CRRS_OP_RETURN |=> o_pop && !o_ready // RULE3
		&& o_carry == $past(o_carry) && o_zero == $past(o_zero)
		&& o_half_carry == $past(o_half_carry) ##1 o_ready)
		else $error("return changed flags or timing wrong");
	rotate_carry_a: assert property (acc && i_op == CRRS_OP_ROTATE_RIGHT_CARRY // RULE4
		|=> o_carry == $past(i_fdata[0]) && o_zero == $past(o_zero))
		else $error("rotate carry wrong");
	rotate_dest_a: assert property (acc && i_op == CRRS_OP_ROTATE_RIGHT_CARRY && !i_dest // RULE5
		|=> o_w == {$past(o_carry), $past(i_fdata[7:1])} && !o_fwrite)
		else $error("rotate result to W wrong");
	sleep_wdt_a: assert property (acc && i_op == CRRS_OP_SLEEP // RULE6
		|=> o_watchdog_counter == 8'h00 && pre_q == 8'h00)
		else $error("sleep did not clear watchdog");
	sleep_flags_a: assert property (acc && i_op == CRRS_OP_SLEEP // RULE7
		|=> !o_power_down_flag_n && o_timeout_flag_n && o_sleep)
		else $error("sleep flags or state wrong");
	sub_value_a: assert property (acc && i_op == CRRS_OP_FILE_MINUS_ACCUMULATOR && i_dest // RULE8
		|=> o_fwrite && o_fwdata == 8'($past(i_fdata) - $past(o_w)))
		else $error("subtract result wrong");
	sub_dest_a: assert property (acc && i_op == CRRS_OP_FILE_MINUS_ACCUMULATOR && !i_dest // RULE9
		|=> !o_fwrite && o_w == 8'($past(i_fdata) - $past(o_w)))
		else $error("subtract to W wrong");
	sub_flags_a: assert property (acc && i_op == CRRS_OP_FILE_MINUS_ACCUMULATOR // RULE10
		|=> o_carry == ($past(o_w) <= $past(i_fdata))
		&& o_half_carry == ($past(o_w[3:0]) <= $past(i_fdata[3:0])))
		else $error("subtract carry flags wrong");

	litret_c: cover property (acc && i_op == CRRS_OP_LITERAL_RETURN ##2 o_ready);
	sleep_wake_c: cover property (o_sleep ##1 i_wake ##1 o_ready);
	sub_zero_c: cover property (acc && i_op == CRRS_OP_FILE_MINUS_ACCUMULATOR ##1 o_zero);

endmodule

// [verification/crrs_mem_model.sv]
// File registers and return stack facing the executor.
// Assumes one write and one pop per clock, on the rising edge.
`timescale 1ns/1ps
`include "crrs_params.svh"

module crrs_mem_model (
	// Clock
	input  wire logic                     i_clk,
	// File read, combinational
	input  wire logic [`CRRS_FADDR_W-1:0] i_rd_addr,
	output logic      [`CRRS_DATA_W-1:0]  o_rd_data,
	// File write
	input  wire logic                     i_wr_en,
	input  wire logic [`CRRS_FADDR_W-1:0] i_wr_addr,
	input  wire logic [`CRRS_DATA_W-1:0]  i_wr_data,
	// Return stack
	input  wire logic                     i_pop,
	output logic      [`CRRS_PTR_W-1:0]   o_head
);
	logic [`CRRS_DATA_W-1:0] mem [0:127];
	logic [3:0]              sp_q;

	initial begin
		for (int a = 0; a < 128; a++) begin
			mem[a] = 8'(a);
		end
		sp_q = 4'h0;
	end

	// Pending write forwarded so back-to-back requests see fresh data
	assign o_rd_data = (i_wr_en && i_wr_addr == i_rd_addr) ? i_wr_data : mem[i_rd_addr];
	assign o_head    = 15'h0100 + 15'(sp_q);

	always @(posedge i_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
		if (i_pop) begin
			sp_q <= sp_q + 4'h1;
		end
	end
endmodule

// [verification/tb_core_return_rotate_sub_sleep.sv]
// Self-checking bench for the return, rotate, sleep and subtract executor.
// Assumes crrs_mem_model supplies file data and the stack head.
`timescale 1ns/1ps
`include "crrs_params.svh"

module tb_core_return_rotate_sub_sleep;
	import crrs_pkg::*;
	typedef struct {
		crrs_op_t op; logic [7:0] lit; logic [6:0] fa; logic d;
		logic [7:0] res; logic [7:0] w; logic [2:0] czd; logic [14:0] ip;
	} crrs_row_t;
	// Flags column is carry, half_carry, zero
	crrs_row_t rows [10] = '{
		'{CRRS_OP_LITERAL_RETURN,         8'h37, 7'h00, 0, 8'h00, 8'h37, 3'h0, 15'h0100},
		'{CRRS_OP_FILE_MINUS_ACCUMULATOR, 8'h00, 7'h50, 0, 8'h19, 8'h19, 3'h4, 15'h0100},
		'{CRRS_OP_ROTATE_RIGHT_CARRY,     8'h00, 7'h03, 0, 8'h81, 8'h81, 3'h4, 15'h0100},
		'{CRRS_OP_RETURN,                 8'h00, 7'h00, 0, 8'h00, 8'h81, 3'h4, 15'h0101},
		'{CRRS_OP_FILE_MINUS_ACCUMULATOR, 8'h00, 7'h7F, 1, 8'hFE, 8'h81, 3'h2, 15'h0101},
		'{CRRS_OP_ROTATE_RIGHT_CARRY,     8'h00, 7'h7F, 1, 8'h7F, 8'h81, 3'h2, 15'h0101},
		'{CRRS_OP_LITERAL_RETURN,         8'hFF, 7'h00, 0, 8'h00, 8'hFF, 3'h2, 15'h0102},
		'{CRRS_OP_FILE_MINUS_ACCUMULATOR, 8'h00, 7'h7F, 0, 8'h80, 8'h80, 3'h2, 15'h0102},
		'{CRRS_OP_LITERAL_RETURN,         8'h00, 7'h00, 0, 8'h00, 8'h00, 3'h2, 15'h0103},
		'{CRRS_OP_FILE_MINUS_ACCUMULATOR, 8'h00, 7'h00, 0, 8'h00, 8'h00, 3'h7, 15'h0103}};
	logic        clk, rstn, valid, dest, wake, ret, rdy, fwr, pop, c, dc, z, pdn, ton, slp;
	crrs_op_t    op;
	logic [7:0]  lit, fdata, fwdata, w, wdt;
	logic [6:0]  faddr, wfaddr;
	logic [14:0] head, ip;
	int          mismatches = 0;
	int          compares = 0;
	int          cycles = 0;

	crrs_core DUT (.i_clk(clk), .i_rstn(rstn), .i_valid(valid), .i_op(op), .i_lit(lit),
		.i_faddr(faddr), .i_dest(dest), .o_ready(rdy), .i_fdata(fdata),
		.i_stack_head_value(head), .i_wake(wake), .o_fwrite(fwr), .o_faddr(wfaddr),
		.o_fwdata(fwdata), .o_pop(pop), .o_instruction_pointer(ip), .o_w(w), .o_carry(c),
		.o_half_carry(dc), .o_zero(z), .o_power_down_flag_n(pdn), .o_timeout_flag_n(ton),
		.o_sleep(slp), .o_watchdog_counter(wdt));
	crrs_mem_model u_mem (.i_clk(clk), .i_rd_addr(faddr), .o_rd_data(fdata), .i_wr_en(fwr),
		.i_wr_addr(wfaddr), .i_wr_data(fwdata), .i_pop(pop), .o_head(head));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic issue(input crrs_op_t o, input logic [7:0] l, input logic [6:0] a, input logic d);
		while (rdy !== 1'b1) begin
			tick();
		end
		valid = 1'b1;
		op = o;
		lit = l;
		faddr = a;
		dest = d;
		tick();
	endtask

	task automatic conclude();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rstn, valid, dest, wake, lit, faddr} = '0;
		op = CRRS_OP_NONE;
		repeat (6) tick();
		chk({rdy, pdn, ton, slp, fwr, pop}, 6'h38);
		chk(w, 8'h00);
		rstn = 1'b1;
		for (int i = 0; i < 10; i++) begin
			issue(rows[i].op, rows[i].lit, rows[i].fa, rows[i].d);
			ret = rows[i].op inside {CRRS_OP_LITERAL_RETURN, CRRS_OP_RETURN};
			chk(w, rows[i].w);
			chk({c, dc, z}, rows[i].czd);
			chk(ip, rows[i].ip);
			chk({pop, rdy}, {ret, !ret});
			chk(fwr, !ret && rows[i].d);
			if (!ret && rows[i].d) begin
				chk({wfaddr, fwdata}, {rows[i].fa, rows[i].res});
			end
			if (ret) begin
				tick();
				chk({pop, rdy}, 2'b01);
			end
		end
		valid = 1'b0;
		repeat (600) tick();
		issue(CRRS_OP_SLEEP, 8'h00, 7'h00, 1'b0);
		chk({slp, rdy, pdn, ton}, 4'h9);
		chk(wdt, 8'h00);
		op = CRRS_OP_LITERAL_RETURN;
		lit = 8'hAA;
		repeat (250) tick();
		chk(wdt, 8'h00);
		chk({w, pop, slp}, {8'h00, 2'b01});
		valid = 1'b0;
		wake = 1'b1;
		tick();
		chk({rdy, slp}, 2'b10);
		wake = 1'b0;
		rstn = 1'b0;
		tick();
		chk({pdn, ton, rdy}, 3'h7);
		rstn = 1'b1;
		issue(CRRS_OP_LITERAL_RETURN, 8'h5A, 7'h00, 1'b0);
		chk({w, pop, rdy}, {8'h5A, 2'b10});
		valid = 1'b0;
		tick();
		conclude();
	end
endmodule
